/* File: core/env_alert_regs.svh */
// Purpose: Constants for the limit alert and offset block
// Assumes: 16-bit measurement codes, 100 MHz system clock
// Notes:   Positions are bit indices inside the 16-bit words
`ifndef ENV_ALERT_REGS_SVH
`define ENV_ALERT_REGS_SVH

`define LIM_SET_HI_DEF 16'hcd33
`define LIM_CLR_HI_DEF 16'hc92d
`define LIM_SET_LO_DEF 16'h3466
`define LIM_CLR_LO_DEF 16'h3869
`define OFS_DEF        16'h0000
`define OFS_CRC_DEF    8'h81

`define LIM_H_MSB      15
`define LIM_H_LSB      9
`define LIM_T_MSB      8
`define LIM_T_LSB      0
`define MEAS_H_LSB     9
`define MEAS_T_LSB     7

`define OFS_H_SIGN     15
`define OFS_H_MSB      14
`define OFS_H_LSB      8
`define OFS_T_SIGN     7
`define OFS_T_MSB      6
`define OFS_T_LSB      0
`define OFS_H_ALIGN    7
`define OFS_T_ALIGN    6

`define CRC_POLY       8'h31
`define CRC_INIT       8'hff

`define CLK_PERIOD_NS      10
`define STORE_PROG_TIME_NS 5000000
`define PROG_CNT_W         24

`endif

/* File: core/env_alert_pkg.sv */
// Purpose: Types shared by the limit alert and offset block
// Assumes: Constants come from env_alert_regs.svh
// Notes:   One packed struct per clock domain holds all state
`default_nettype none
`include "env_alert_regs.svh"
package env_alert_pkg;

  typedef enum logic [2:0] {
    CMD_SET_HI,
    CMD_CLR_HI,
    CMD_SET_LO,
    CMD_CLR_LO,
    CMD_OFFSET,
    CMD_STORE,
    CMD_SOFT_RST
  } cmd_e;

  typedef struct packed {
    logic [15:0] set_hi;
    logic [15:0] clr_hi;
    logic [15:0] set_lo;
    logic [15:0] clr_lo;
  } limits_s;

  typedef struct packed {
    logic t_hi;
    logic t_lo;
    logic h_hi;
    logic h_lo;
  } flags_s;

  typedef struct packed {
    limits_s                 lim;
    logic [15:0]             ofs;
    limits_s                 nv_lim;
    logic [15:0]             nv_ofs;
    flags_s                  flg;
    logic [15:0]             t_res;
    logic [15:0]             h_res;
    logic                    res_valid;
    logic                    req_meta;
    logic                    req_sync;
    logic                    req_seen;
    logic                    ack_tgl;
    logic [`PROG_CNT_W-1:0]  prog_cnt;
    logic                    busy;
  } sys_state_s;

  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    logic        busy_meta;
    logic        busy_sync;
    logic        ack_meta;
    logic        ack_sync;
    logic        req_tgl;
    cmd_e        cmd;
    logic [15:0] data;
    logic        ack;
    logic        nack;
  } link_state_s;

endpackage : env_alert_pkg
`default_nettype wire

/* File: core/env_alert.sv */
// Purpose: Limit alert with hysteresis and signed result offsets
// Assumes: Link side runs on link_clk; measurements arrive on clk_sys
// Notes:   Persistent store survives sys_rst, only por loads factory
`default_nettype none
`include "env_alert_regs.svh"

module env_alert
  import env_alert_pkg::*;
#(
  parameter int unsigned STORE_PROG_CYCLES =
    `STORE_PROG_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        por,
  input  wire logic        meas_valid,
  input  wire logic [15:0] meas_temp,
  input  wire logic [15:0] meas_hum,
  input  wire logic        status_clear,
  output logic [15:0]      temp_result,
  output logic [15:0]      hum_result,
  output logic             result_valid,
  output limits_s          limits,
  output logic [15:0]      offset_word,
  output flags_s           event_flags,
  output logic             alert,
  output logic             store_busy,
  input  wire logic        link_clk,
  input  wire logic        link_cmd_valid,
  input  wire cmd_e        link_cmd,
  input  wire logic [15:0] link_data,
  input  wire logic [7:0]  link_crc,
  output logic             link_ack,
  output logic             link_nack
);

  localparam logic [`PROG_CNT_W-1:0] PROG_LAST =
    `PROG_CNT_W'(STORE_PROG_CYCLES - 1);

  sys_state_s  s_reg;
  sys_state_s  s_next;
  link_state_s l_reg;
  link_state_s l_next;

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Saturates rather than wraps so a big offset cannot flip the scale
  function automatic logic [15:0] apply_ofs(
    input logic [15:0] raw,
    input logic [15:0] delta,
    input logic        add
  );
    logic [16:0] s;
    s = add ? {1'b0, raw} + {1'b0, delta}
            : {1'b0, raw} - {1'b0, delta};
    if (s[16]) begin
      return add ? 16'hffff : 16'h0000;
    end
    return s[15:0];
  endfunction

  // Measurement path and limit fields
  logic [15:0] t_delta;
  logic [15:0] h_delta;
  logic [15:0] t_adj;
  logic [15:0] h_adj;
  logic [8:0]  t_tr;
  logic [6:0]  h_tr;
  logic [8:0]  sh_t;
  logic [8:0]  ch_t;
  logic [8:0]  sl_t;
  logic [8:0]  cl_t;
  logic [6:0]  sh_h;
  logic [6:0]  ch_h;
  logic [6:0]  sl_h;
  logic [6:0]  cl_h;
  logic        t_en;
  logic        h_en;
  logic        req_new;

  always_comb begin
    t_delta = 16'(s_reg.ofs[`OFS_T_MSB:`OFS_T_LSB]) << `OFS_T_ALIGN;
    h_delta = 16'(s_reg.ofs[`OFS_H_MSB:`OFS_H_LSB]) << `OFS_H_ALIGN;
    t_adj = apply_ofs(meas_temp, t_delta,
                      s_reg.ofs[`OFS_T_SIGN]);
    // Humidity sees only the raw humidity and its own offset
    h_adj = apply_ofs(meas_hum, h_delta,
                      s_reg.ofs[`OFS_H_SIGN]);
    t_tr = t_adj[15:`MEAS_T_LSB];
    h_tr = h_adj[15:`MEAS_H_LSB];
    sh_t = s_reg.lim.set_hi[`LIM_T_MSB:`LIM_T_LSB];
    ch_t = s_reg.lim.clr_hi[`LIM_T_MSB:`LIM_T_LSB];
    sl_t = s_reg.lim.set_lo[`LIM_T_MSB:`LIM_T_LSB];
    cl_t = s_reg.lim.clr_lo[`LIM_T_MSB:`LIM_T_LSB];
    sh_h = s_reg.lim.set_hi[`LIM_H_MSB:`LIM_H_LSB];
    ch_h = s_reg.lim.clr_hi[`LIM_H_MSB:`LIM_H_LSB];
    sl_h = s_reg.lim.set_lo[`LIM_H_MSB:`LIM_H_LSB];
    cl_h = s_reg.lim.clr_lo[`LIM_H_MSB:`LIM_H_LSB];
    t_en = !(sl_t > sh_t);
    h_en = !(sl_h > sh_h);
    req_new = s_reg.req_sync != s_reg.req_seen;
  end

  // System domain
  always_comb begin
    s_next = s_reg;
    s_next.req_meta = l_reg.req_tgl;
    s_next.req_sync = s_reg.req_meta;
    s_next.res_valid = 1'b0;

    // A clear loses to an event found in the same cycle
    if (status_clear) begin
      s_next.flg = '0;
    end

    if (meas_valid) begin
      s_next.t_res = t_adj;
      s_next.h_res = h_adj;
      s_next.res_valid = 1'b1;
      if (t_tr > sh_t) begin
        s_next.flg.t_hi = 1'b1;
      end else if (t_tr < ch_t) begin
        s_next.flg.t_hi = 1'b0;
      end
      if (t_tr < sl_t) begin
        s_next.flg.t_lo = 1'b1;
      end else if (t_tr > cl_t) begin
        s_next.flg.t_lo = 1'b0;
      end
      if (h_tr > sh_h) begin
        s_next.flg.h_hi = 1'b1;
      end else if (h_tr < ch_h) begin
        s_next.flg.h_hi = 1'b0;
      end
      if (h_tr < sl_h) begin
        s_next.flg.h_lo = 1'b1;
      end else if (h_tr > cl_h) begin
        s_next.flg.h_lo = 1'b0;
      end
    end
    if (!t_en) begin
      s_next.flg.t_hi = 1'b0;
      s_next.flg.t_lo = 1'b0;
    end
    if (!h_en) begin
      s_next.flg.h_hi = 1'b0;
      s_next.flg.h_lo = 1'b0;
    end

    if (s_reg.busy) begin
      if (s_reg.prog_cnt == PROG_LAST) begin
        s_next.busy = 1'b0;
        s_next.prog_cnt = '0;
      end else begin
        s_next.prog_cnt = s_reg.prog_cnt + 1'b1;
      end
    end

    // Link data is held stable until our acknowledge toggles back
    if (req_new) begin
      s_next.req_seen = s_reg.req_sync;
      s_next.ack_tgl = s_reg.req_sync;
      unique case (l_reg.cmd)
        CMD_SET_HI: s_next.lim.set_hi = l_reg.data;
        CMD_CLR_HI: s_next.lim.clr_hi = l_reg.data;
        CMD_SET_LO: s_next.lim.set_lo = l_reg.data;
        CMD_CLR_LO: s_next.lim.clr_lo = l_reg.data;
        CMD_OFFSET: begin
          s_next.ofs = l_reg.data;
          s_next.nv_ofs = l_reg.data;
          s_next.busy = 1'b1;
          s_next.prog_cnt = '0;
        end
        CMD_STORE: begin
          s_next.nv_lim = s_reg.lim;
          s_next.busy = 1'b1;
          s_next.prog_cnt = '0;
        end
        CMD_SOFT_RST: begin
          s_next.lim = s_reg.nv_lim;
          s_next.ofs = s_reg.nv_ofs;
          s_next.flg = '0;
          s_next.t_res = '0;
          s_next.h_res = '0;
        end
        default: ;
      endcase
    end

    // Hardware reset keeps the persistent store, power-on refills it
    if (sys_rst || por) begin
      if (por) begin
        s_next.nv_lim = '{`LIM_SET_HI_DEF, `LIM_CLR_HI_DEF,
                          `LIM_SET_LO_DEF, `LIM_CLR_LO_DEF};
        s_next.nv_ofs = `OFS_DEF;
        s_next.lim = '{`LIM_SET_HI_DEF, `LIM_CLR_HI_DEF,
                       `LIM_SET_LO_DEF, `LIM_CLR_LO_DEF};
        s_next.ofs = `OFS_DEF;
      end else begin
        s_next.nv_lim = s_reg.nv_lim;
        s_next.nv_ofs = s_reg.nv_ofs;
        s_next.lim = s_reg.nv_lim;
        s_next.ofs = s_reg.nv_ofs;
      end
      s_next.flg = '0;
      s_next.t_res = '0;
      s_next.h_res = '0;
      s_next.res_valid = 1'b0;
      s_next.req_meta = 1'b0;
      s_next.req_sync = 1'b0;
      s_next.req_seen = 1'b0;
      s_next.ack_tgl = 1'b0;
      s_next.prog_cnt = '0;
      s_next.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_reg <= s_next;
  end

  // Link domain
  logic data_cmd;
  logic crc_ok;
  logic pending;

  always_comb begin
    data_cmd = link_cmd inside {CMD_SET_HI, CMD_CLR_HI, CMD_SET_LO,
                                CMD_CLR_LO, CMD_OFFSET};
    crc_ok = crc8(link_data) == link_crc;
    pending = l_reg.req_tgl != l_reg.ack_sync;
  end

  always_comb begin
    l_next = l_reg;
    l_next.rst_meta = sys_rst | por;
    l_next.rst_sync = l_reg.rst_meta;
    l_next.busy_meta = s_reg.busy;
    l_next.busy_sync = l_reg.busy_meta;
    l_next.ack_meta = s_reg.ack_tgl;
    l_next.ack_sync = l_reg.ack_meta;
    l_next.ack = 1'b0;
    l_next.nack = 1'b0;
    if (link_cmd_valid) begin
      // Busy store or unfinished hand-over refuses the new word
      if (pending || l_reg.busy_sync) begin
        l_next.nack = 1'b1;
      end else if (data_cmd && !crc_ok) begin
        l_next.nack = 1'b1;
      end else if (link_cmd inside {CMD_STORE, CMD_SOFT_RST}
                   || data_cmd) begin
        l_next.ack = 1'b1;
        l_next.cmd = link_cmd;
        l_next.data = link_data;
        l_next.req_tgl = !l_reg.req_tgl;
      end else begin
        l_next.nack = 1'b1;
      end
    end
    if (l_reg.rst_sync) begin
      l_next.req_tgl = 1'b0;
      l_next.cmd = CMD_SET_HI;
      l_next.data = '0;
      l_next.ack = 1'b0;
      l_next.nack = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    l_reg <= l_next;
  end

  // Outputs
  assign temp_result = s_reg.t_res;
  assign hum_result = s_reg.h_res;
  assign result_valid = s_reg.res_valid;
  assign limits = s_reg.lim;
  assign offset_word = s_reg.ofs;
  assign event_flags = s_reg.flg;
  assign alert = |s_reg.flg;
  assign store_busy = s_reg.busy;
  assign link_ack = l_reg.ack;
  assign link_nack = l_reg.nack;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || por);

  a_temp_hi_set: assert property (
    meas_valid && t_en && t_tr > sh_t |=> s_reg.flg.t_hi
  ) else $error("temperature high flag not set");

  a_temp_hi_hold: assert property (
    !status_clear && meas_valid && t_en && s_reg.flg.t_hi && t_tr >= ch_t
    |=> s_reg.flg.t_hi
  ) else $error("temperature high flag dropped early");

  a_hum_lo_set: assert property (
    meas_valid && h_en && h_tr < sl_h |=> s_reg.flg.h_lo
  ) else $error("humidity low flag not set");

  a_temp_lo_clear: assert property (
    meas_valid && t_tr > cl_t && !(t_tr < sl_t) |=> !s_reg.flg.t_lo
  ) else $error("temperature low flag not released");

  a_temp_track_off: assert property (
    !t_en |=> !s_reg.flg.t_hi && !s_reg.flg.t_lo
  ) else $error("temperature tracked while disabled");

  a_hum_track_off: assert property (
    !h_en |=> !s_reg.flg.h_hi && !s_reg.flg.h_lo
  ) else $error("humidity tracked while disabled");

  a_hum_no_toffs: assert property (
    meas_valid && s_reg.ofs[`OFS_H_MSB:`OFS_H_LSB] == 7'h00
    |=> hum_result == $past(meas_hum)
  ) else $error("humidity result moved by temperature offset");

  a_store_busy_min: assert property (
    $rose(s_reg.busy) |-> s_reg.busy [*8]
  ) else $error("store programming ended too soon");

  a_alert_clear: assert property (
    status_clear && !meas_valid |=> !alert
  ) else $error("alert stayed after status clear");

  a_reset_reload: assert property (
    disable iff (por)
    sys_rst |=> s_reg.lim == $past(s_reg.nv_lim)
  ) else $error("reset did not reload stored limits");

  a_por_defaults: assert property (
    disable iff (1'b0)
    por |=> s_reg.lim.set_hi == `LIM_SET_HI_DEF
         && s_reg.lim.clr_lo == `LIM_CLR_LO_DEF
  ) else $error("power-on limits not at defaults");

  a_crc_refuse: assert property (
    @(posedge link_clk) disable iff (l_reg.rst_sync)
    link_cmd_valid && data_cmd && !crc_ok
    |=> link_nack && !link_ack
  ) else $error("bad CRC word was not refused");

endmodule : env_alert
`default_nettype wire

/* File: sim/link_host.sv */
// Purpose: Link-side controller model that issues framed commands
// Assumes: Frames are launched on the falling edge of link_clk
// Notes:   Released data lines show the inverse of their last value
`default_nettype none
module link_host
  import env_alert_pkg::*;
(
  input  wire logic  link_clk,
  input  wire logic  link_ack,
  input  wire logic  link_nack,
  output logic        link_cmd_valid,
  output cmd_e        link_cmd,
  output logic [15:0] link_data,
  output logic [7:0]  link_crc
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_cmd_valid = 1'b0;
    link_cmd = CMD_STORE;
    link_data = 16'h0000;
    link_crc = 8'h00;
  end

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  // ok is 1 on ack, 0 on nack, x when neither came back
  task automatic send(input cmd_e c, input logic [15:0] d,
                      input logic bad, output logic ok);
    ok = 1'bx;
    @(negedge link_clk);
    link_cmd_valid = 1'b1;
    link_cmd = c;
    link_data = d;
    link_crc = crc8(d) ^ {7'h00, bad};
    @(negedge link_clk);
    link_cmd_valid = 1'b0;
    link_data = ~d;
    link_crc = ~link_crc;
    repeat (2) begin
      if (link_ack === 1'b1) ok = 1'b1;
      if (link_nack === 1'b1) ok = 1'b0;
      @(negedge link_clk);
    end
    // Let the handover to the system side finish before the next frame
    repeat (4) @(negedge link_clk);
  endtask
endmodule // link_host
`default_nettype wire

/* File: sim/env_alert_tb.sv */
// Purpose: Self-checking bench for the limit alert and offset block
// Assumes: Short store time; inputs change on falling clock edges
// Notes:   Expected values come from a model kept in this bench
`default_nettype none
module env_alert_tb
  import env_alert_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] t;
    logic [15:0] h;
    flags_s      f;
  } note_s;
  logic clk_sys, sys_rst, por, meas_valid, status_clear, link_clk, ok;
  logic [15:0] meas_temp, meas_hum, temp_result, hum_result, offset_word;
  logic result_valid, alert, store_busy, link_cmd_valid, link_ack, link_nack;
  logic [15:0] link_data, ofs, nv_ofs;
  logic [7:0]  link_crc;
  limits_s     limits;
  flags_s      event_flags, fl;
  cmd_e        link_cmd;
  note_s       nt;
  note_s       q[$];
  logic [15:0] lim [4];
  logic [15:0] nv_lim [4];
  logic [15:0] tv [6] = '{16'h9a00, 16'h9800, 16'h9600, 16'h3280,
                          16'h3400, 16'h3500};
  logic [15:0] hv [6] = '{16'hce00, 16'hca00, 16'hc600, 16'h3200,
                          16'h3600, 16'h3a00};
  // First word moves temperature only, humidity must stay raw
  logic [15:0] ow [4] = '{16'h00bf, 16'hab2a, 16'hff7f, 16'h7f7f};
  int mismatches, n_tests, cyc, seed;

  env_alert #(.STORE_PROG_CYCLES(200)) env_alert_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .por(por),
    .meas_valid(meas_valid), .meas_temp(meas_temp), .meas_hum(meas_hum),
    .status_clear(status_clear), .temp_result(temp_result),
    .hum_result(hum_result), .result_valid(result_valid),
    .limits(limits), .offset_word(offset_word),
    .event_flags(event_flags), .alert(alert), .store_busy(store_busy),
    .link_clk(link_clk), .link_cmd_valid(link_cmd_valid),
    .link_cmd(link_cmd), .link_data(link_data), .link_crc(link_crc),
    .link_ack(link_ack), .link_nack(link_nack));
  link_host link_host_inst (
    .link_clk(link_clk), .link_ack(link_ack), .link_nack(link_nack),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
    .link_data(link_data), .link_crc(link_crc));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Odd start offset keeps the link clock out of phase with clk_sys
  initial begin
    link_clk = 1'b0;
    #17.3;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude();
    end
  end

  always @(negedge clk_sys) begin
    if (result_valid === 1'b1) begin
      if (q.size() == 0) begin
        chk("result_valid", 64'h0, 64'h1);
      end else begin
        nt = q.pop_front();
        chk("temp_result", nt.t, temp_result);
        chk("hum_result", nt.h, hum_result);
        chk("event_flags", nt.f, event_flags);
        chk("alert", nt.f != 4'h0, alert);
      end
    end
  end

  function automatic logic [15:0] adj(input logic [15:0] r, d,
                                      input logic add);
    logic [16:0] s;
    s = add ? {1'b0, r} + d : {1'b0, r} - d;
    if (s[16]) return add ? 16'hffff : 16'h0000;
    return s[15:0];
  endfunction

  function automatic logic [1:0] upd(input logic [8:0] v, sh, ch, sl, cl,
                                     input logic [1:0] f);
    logic [1:0] n;
    n = f;
    if (v > sh) n[1] = 1'b1;
    else if (v < ch) n[1] = 1'b0;
    if (v < sl) n[0] = 1'b1;
    else if (v > cl) n[0] = 1'b0;
    return (sl > sh) ? 2'b00 : n;
  endfunction

  task automatic meas(input logic [15:0] t, h);
    logic [15:0] at, ah;
    at = adj(t, {3'h0, ofs[6:0], 6'h00}, ofs[7]);
    ah = adj(h, {2'h0, ofs[14:8], 7'h00}, ofs[15]);
    {fl.t_hi, fl.t_lo} = upd(at[15:7], lim[0][8:0], lim[1][8:0],
      lim[2][8:0], lim[3][8:0], {fl.t_hi, fl.t_lo});
    {fl.h_hi, fl.h_lo} = upd({2'h0, ah[15:9]}, {2'h0, lim[0][15:9]},
      {2'h0, lim[1][15:9]}, {2'h0, lim[2][15:9]}, {2'h0, lim[3][15:9]},
      {fl.h_hi, fl.h_lo});
    q.push_back({at, ah, fl});
    @(negedge clk_sys);
    meas_valid = 1'b1;
    meas_temp = t;
    meas_hum = h;
    @(negedge clk_sys);
    meas_valid = 1'b0;
  endtask

  task automatic reload();
    lim = nv_lim;
    ofs = nv_ofs;
    fl = '0;
  endtask

  function automatic logic [63:0] lw();
    return {lim[0], lim[1], lim[2], lim[3]};
  endfunction

  task automatic cmd(input cmd_e c, input logic [15:0] d,
                     input logic bad, exp);
    link_host_inst.send(c, d, bad, ok);
    chk("link answer", exp, ok);
    if (ok === 1'b1) begin
      if (c == CMD_OFFSET) begin
        ofs = d;
        nv_ofs = d;
      end else if (c == CMD_STORE) nv_lim = lim;
      else if (c == CMD_SOFT_RST) reload();
      else lim[int'(c)] = d;
      if (lim[2][8:0] > lim[0][8:0]) {fl.t_hi, fl.t_lo} = 2'b00;
      if (lim[2][15:9] > lim[0][15:9]) {fl.h_hi, fl.h_lo} = 2'b00;
    end
    repeat (6) @(negedge clk_sys);
    chk("limits", {lim[0], lim[1], lim[2], lim[3]}, limits);
    chk("offset_word", ofs, offset_word);
  endtask

  task automatic idle();
    for (int i = 0; i < 400 && store_busy !== 1'b0; i++) @(negedge clk_sys);
    chk("store_busy", 1'b0, store_busy);
    repeat (3) @(posedge link_clk);
  endtask

  // Reset must span link edges so the link side sees it too
  task automatic do_rst(input logic p);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    por = p;
    repeat (3) @(posedge link_clk);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    por = 1'b0;
    if (p) begin
      nv_lim = '{16'hcd33, 16'hc92d, 16'h3466, 16'h3869};
      nv_ofs = 16'h0000;
    end
    reload();
    repeat (40) @(negedge clk_sys);
    chk("limits", lw(), limits);
    chk("offset_word", ofs, offset_word);
    chk("alert", 1'b0, alert);
  endtask

  initial begin
    seed = 43920;
    {sys_rst, por, meas_valid, status_clear} = 4'hc;
    {meas_temp, meas_hum} = 32'h0;
    {mismatches, n_tests, cyc} = '0;
    do_rst(1'b1);
    foreach (tv[i]) meas(tv[i], 16'h8000);
    foreach (hv[i]) meas(16'h6000, hv[i]);
    meas(16'h9a00, 16'h8000);
    @(negedge clk_sys);
    status_clear = 1'b1;
    fl = '0;
    @(negedge clk_sys);
    status_clear = 1'b0;
    chk("alert", 1'b0, alert);
    // Clear and a setting result in one cycle: the set survives
    meas(16'h6000, 16'h3200);
    fl = '0;
    fork
      meas(16'h9a00, 16'h3600);
      begin
        @(negedge clk_sys);
        status_clear = 1'b1;
        @(negedge clk_sys);
        status_clear = 1'b0;
      end
    join
    repeat (20) meas(16'($random(seed)), 16'($random(seed)));
    cmd(CMD_SET_HI, 16'he741, 1'b0, 1'b1);
    cmd(CMD_CLR_HI, 16'h1234, 1'b1, 1'b0);
    cmd(cmd_e'(3'h7), 16'h0000, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(cmd_e'(i), 16'($random(seed)), 1'b0, 1'b1);
      repeat (4) meas(16'($random(seed)), 16'($random(seed)));
    end
    cmd(CMD_SET_HI, 16'h4000, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      cmd(CMD_SET_LO, i ? 16'h80ff : 16'h00ff, 1'b0, 1'b1);
      meas(16'h0000, 16'h0000);
      meas(16'hffff, 16'hffff);
    end
    cmd(CMD_STORE, 16'h0000, 1'b0, 1'b1);
    idle();
    foreach (ow[i]) begin
      cmd(CMD_OFFSET, ow[i], 1'b0, 1'b1);
      chk("store_busy", 1'b1, store_busy);
      cmd(CMD_CLR_LO, 16'h5555, 1'b0, 1'b0);
      idle();
      meas(16'h0000, 16'h0000);
      meas(16'hffff, 16'hffff);
      repeat (3) meas(16'($random(seed)), 16'($random(seed)));
    end
    do_rst(1'b0);
    cmd(CMD_SET_HI, 16'h0000, 1'b0, 1'b1);
    meas(16'h8000, 16'h8000);
    cmd(CMD_SOFT_RST, 16'h0000, 1'b0, 1'b1);
    chk("alert", 1'b0, alert);
    meas(16'h8000, 16'h8000);
    do_rst(1'b1);
    repeat (4) @(negedge clk_sys);
    chk("pending results", 0, q.size());
    conclude();
  end
endmodule // env_alert_tb
`default_nettype wire
